// ### core/spl_pkg.sv
// Purpose: Shared constants and types of the serial programming link block
// Assumes: I/O space addresses are six bits wide
// Notes:   Frame and guard figures are counted in link clock bits
package spl_pkg;
  localparam logic [5:0] SPL_CSR_ADDR     = 6'h32;
  localparam logic [5:0] SPL_CMD_ADDR     = 6'h33;
  localparam logic [7:0] SPL_CSR_RESET    = 8'h00;
  localparam logic [5:0] SPL_CMD_RESET    = 6'h00;
  localparam int         SPL_BUSY_BIT     = 7;
  localparam int         SPL_CMD_W        = 6;
  localparam logic [5:0] SPL_CMD_NOP      = 6'h00;
  localparam logic [5:0] SPL_CMD_CHIP_ER  = 6'h10;
  localparam logic [5:0] SPL_CMD_CHIP_WR  = 6'h11;
  localparam logic [5:0] SPL_CMD_SECT_ER  = 6'h14;
  localparam logic [5:0] SPL_CMD_WORD_WR  = 6'h1D;
  localparam logic [5:0] SPL_CMD_PAGE_ER  = 6'h18;
  localparam logic [3:0] SPL_FRAME_BITS   = 4'hC;
  localparam logic [3:0] SPL_RX_LAST      = 4'hA;
  localparam logic [7:0] SPL_GUARD_BITS   = 8'h80;
  localparam logic [7:0] SPL_IDLE_MIN     = 8'h02;
  localparam logic [7:0] SPL_GUARD_TOTAL  = SPL_GUARD_BITS + SPL_IDLE_MIN;
  // Sync bit order: clock, data, reset pin, high voltage
  localparam int         SPL_SYNC_W       = 4;
  localparam logic [3:0] SPL_SYNC_INIT    = 4'h6;
  localparam int         SPL_IX_CLK       = 0;
  localparam int         SPL_IX_DAT       = 1;
  localparam int         SPL_IX_RSTN      = 2;
  localparam int         SPL_IX_HV        = 3;

  typedef enum logic [5:0] {
    SPL_OFF      = 6'b00_0001,
    SPL_RX_IDLE  = 6'b00_0010,
    SPL_RX_BITS  = 6'b00_0100,
    SPL_RX_WAITH = 6'b00_1000,
    SPL_TX_GUARD = 6'b01_0000,
    SPL_TX_BITS  = 6'b10_0000
  } spl_state_e;
endpackage

// ### core/spl_sync.sv
// Purpose: Two-stage synchroniser for pins entering the mclk domain
// Assumes: Inputs are quasi-static relative to the 10 ns clock
// Notes:   Only the second stage is visible outside
`timescale 1ns/1ns
`default_nettype none
module spl_sync
  import spl_pkg::*;
#(
  parameter int unsigned     W    = 1,
  parameter logic [W-1:0]    INIT = '0
) (
  input  wire logic          mclk_i,
  input  wire logic          rst_i,
  input  wire logic          ce_i,
  input  wire logic [W-1:0]  async_i,
  output logic      [W-1:0]  sync_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } spl_sync_s;

  spl_sync_s s_q;
  spl_sync_s s_d;

  always_comb begin
    s_d    = s_q;
    s_d.s1 = async_i;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '{s1: INIT, s2: INIT};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign sync_o = s_q.s2;
endmodule
`default_nettype wire

// ### core/spl_nvm_regs.sv
// Purpose: Memory controller status and command registers with start logic
// Assumes: The memory array reports completion with a one-cycle done pulse
// Notes:   Command writes are blocked while an operation is running
`timescale 1ns/1ns
`default_nettype none
module spl_nvm_regs
  import spl_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic [5:0]           io_addr_i,
  input  wire logic                 io_wr_i,
  input  wire logic [7:0]           io_wdata_i,
  output logic      [7:0]           io_rdata_o,
  input  wire logic                 self_prog_i,
  input  wire logic                 mem_start_i,
  input  wire logic                 nvm_done_i,
  output logic                      busy_o,
  output logic                      nvm_go_o,
  output logic      [SPL_CMD_W-1:0] nvm_cmd_o,
  output logic                      erase_code_o,
  output logic                      erase_lock_o,
  output logic                      write_code_o
);
  typedef struct packed {
    logic [SPL_CMD_W-1:0] cmd;
    logic                 busy;
    logic                 go;
    logic                 er_code;
    logic                 er_lock;
    logic                 wr_code;
    logic [7:0]           rdata;
  } spl_regs_s;

  spl_regs_s s_q;
  spl_regs_s s_d;
  logic      wr_ok;
  logic      known;
  logic      self_ok;

  function automatic logic spl_self_allowed(input logic [SPL_CMD_W-1:0] c);
    spl_self_allowed = (c == SPL_CMD_NOP) || (c == SPL_CMD_WORD_WR) || (c == SPL_CMD_PAGE_ER);
  endfunction

  always_comb begin
    s_d     = s_q;
    s_d.go  = 1'b0;
    wr_ok   = !self_prog_i || spl_self_allowed(io_wdata_i[SPL_CMD_W-1:0]);
    self_ok = !self_prog_i || spl_self_allowed(s_q.cmd);
    known   = (s_q.cmd == SPL_CMD_CHIP_ER) || (s_q.cmd == SPL_CMD_CHIP_WR)
           || (s_q.cmd == SPL_CMD_SECT_ER) || (s_q.cmd == SPL_CMD_WORD_WR)
           || (s_q.cmd == SPL_CMD_PAGE_ER);
    if (io_wr_i && io_addr_i == SPL_CMD_ADDR && !s_q.busy && wr_ok) begin
      s_d.cmd = io_wdata_i[SPL_CMD_W-1:0];
    end
    if (nvm_done_i) begin
      s_d.busy = 1'b0;
    end
    // Start is refused while busy, so a start in the cycle of the done that ends an operation is lost
    if (mem_start_i && !s_q.busy && known && self_ok) begin
      s_d.busy    = 1'b1;
      s_d.go      = 1'b1;
      s_d.er_code = (s_q.cmd == SPL_CMD_CHIP_ER) || (s_q.cmd == SPL_CMD_SECT_ER);
      s_d.er_lock = (s_q.cmd == SPL_CMD_CHIP_ER);
      s_d.wr_code = (s_q.cmd == SPL_CMD_CHIP_WR) || (s_q.cmd == SPL_CMD_WORD_WR);
    end
    if (io_addr_i == SPL_CSR_ADDR) begin
      s_d.rdata = {s_q.busy, 7'h00};
    end else if (io_addr_i == SPL_CMD_ADDR) begin
      s_d.rdata = {2'h0, s_q.cmd};
    end else begin
      s_d.rdata = 8'h00;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '{cmd: SPL_CMD_RESET, rdata: SPL_CSR_RESET, default: '0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign io_rdata_o   = s_q.rdata;
  assign busy_o       = s_q.busy;
  assign nvm_go_o     = s_q.go;
  assign nvm_cmd_o    = s_q.cmd;
  assign erase_code_o = s_q.er_code;
  assign erase_lock_o = s_q.er_lock;
  assign write_code_o = s_q.wr_code;

  a_busy_holds: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.go ##1 !nvm_done_i) |-> s_q.busy)
    else $error("busy dropped before operation completed");
  a_cmd_blocked: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && io_wr_i && self_prog_i && io_addr_i == SPL_CMD_ADDR
     && !spl_self_allowed(io_wdata_i[SPL_CMD_W-1:0])) |=> $stable(s_q.cmd))
    else $error("self programming accepted a forbidden command");
  a_chip_erase: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.go && s_q.cmd == SPL_CMD_CHIP_ER) |-> (s_q.er_code && s_q.er_lock))
    else $error("chip erase did not cover code and lock bits");
  a_rdata_clean: assert property (@(posedge mclk_i) disable iff (rst_i)
    ($past(io_addr_i) == SPL_CMD_ADDR && $past(ce_i)) |-> (io_rdata_o[7:6] == 2'h0))
    else $error("reserved command bits read non-zero");
endmodule
`default_nettype wire

// ### core/spl_link.sv
// Purpose: Target end of a three-pin serial programming link and its memory registers
// Assumes: The access layer above drives tx requests and the programming enable bit
// Notes:   Link pins are sampled by mclk; link clock must be well below 50 MHz
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// - Busy flag rises at operation start and holds until completion.
// - Command register holds six-bit command in bits 5:0, reset zero.
// - Commands decode as nop, chip erase/write, section erase, word write, page erase.
// - Chip erase clears both code section and lock bits.
// - Chip write programs code section, lock bits untouched.
// - Self programming accepts only nop, word write and page erase.
// - Link reaches controller registers in I/O space and memory in data space.
// - Link uses reset as enable, a clock pin and one bidirectional data pin.
// - With enable bit clear, releasing reset or high voltage disables the link.
// - With enable bit set, releasing reset keeps the session; only power-down ends it.
// - Frame is low start, eight data, parity and two high stop bits.
// - Data bits travel least significant bit first.
// - Parity is even, xor of data bits; generated on send, checked on receive.
// - Detect parity, frame and break on receive, collisions on transmit.
// - One shared data line, half duplex, serial-parallel conversion both ways.
// - Idle guard bits are inserted on each turn from receive to transmit.
// - Data changes on falling link clock edges, sampled on rising edges.
// - Break is a low level of twelve or more bit periods.
// - Zero stop bit flags frame error; all-zero frame flags break.
// - Default guard time is 128 bits plus two mandatory idle bits.
module spl_link
  import spl_pkg::*;
(
  input  wire logic                 mclk_i,
  input  wire logic                 rst_i,
  input  wire logic                 ce_i,
  input  wire logic                 link_reset_n_i,
  input  wire logic                 link_hv_i,
  input  wire logic                 link_clock_pin_i,
  input  wire logic                 link_data_pin_i,
  output logic                      link_data_pin_o,
  output logic                      link_data_pin_oe_o,
  input  wire logic                 programming_enable_bit_i,
  output logic                      link_enabled_o,
  output logic      [7:0]           rx_data_o,
  output logic                      rx_valid_o,
  output logic                      rx_parity_err_o,
  output logic                      rx_frame_err_o,
  output logic                      rx_break_o,
  input  wire logic                 tx_start_i,
  input  wire logic [7:0]           tx_data_i,
  output logic                      tx_ready_o,
  output logic                      tx_busy_o,
  output logic                      tx_collision_o,
  input  wire logic [5:0]           io_addr_i,
  input  wire logic                 io_wr_i,
  input  wire logic [7:0]           io_wdata_i,
  output logic      [7:0]           io_rdata_o,
  input  wire logic                 self_prog_i,
  input  wire logic                 mem_wr_i,
  input  wire logic                 mem_hi_byte_i,
  input  wire logic                 nvm_done_i,
  output logic                      memory_busy_flag_o,
  output logic                      nvm_go_o,
  output logic      [SPL_CMD_W-1:0] nvm_cmd_o,
  output logic                      erase_code_o,
  output logic                      erase_lock_o,
  output logic                      write_code_o
);
  typedef struct packed {
    spl_state_e  st;
    logic        en;
    logic        clk_prev;
    logic [3:0]  bitc;
    logic [11:0] sh;
    logic [7:0]  guard;
    logic        prev_zero;
    logic        oe;
    logic        dout;
    logic [7:0]  rx_data;
    logic        rx_par;
    logic        rx_valid;
    logic        perr;
    logic        ferr;
    logic        brk;
    logic        coll;
  } spl_link_s;

  spl_link_s                 s_q;
  spl_link_s                 s_d;
  logic [SPL_SYNC_W-1:0]     pins_s;
  logic                      clk_s;
  logic                      dat_s;
  logic                      pin_active;
  logic                      rise;
  logic                      fall;
  logic [11:0]               nsh;
  logic                      tx_bit;
  logic                      mem_start;

  spl_sync #(
    .W    (SPL_SYNC_W),
    .INIT (SPL_SYNC_INIT)
  ) u_sync (
    .mclk_i  (mclk_i),
    .rst_i   (rst_i),
    .ce_i    (ce_i),
    .async_i ({link_hv_i, link_reset_n_i, link_data_pin_i, link_clock_pin_i}),
    .sync_o  (pins_s)
  );

  // Data-space write to the high byte of a word launches the loaded command
  assign mem_start = mem_wr_i && mem_hi_byte_i;

  spl_nvm_regs u_regs (
    .mclk_i       (mclk_i),
    .rst_i        (rst_i),
    .ce_i         (ce_i),
    .io_addr_i    (io_addr_i),
    .io_wr_i      (io_wr_i),
    .io_wdata_i   (io_wdata_i),
    .io_rdata_o   (io_rdata_o),
    .self_prog_i  (self_prog_i),
    .mem_start_i  (mem_start),
    .nvm_done_i   (nvm_done_i),
    .busy_o       (memory_busy_flag_o),
    .nvm_go_o     (nvm_go_o),
    .nvm_cmd_o    (nvm_cmd_o),
    .erase_code_o (erase_code_o),
    .erase_lock_o (erase_lock_o),
    .write_code_o (write_code_o)
  );

  assign clk_s      = pins_s[SPL_IX_CLK];
  assign dat_s      = pins_s[SPL_IX_DAT];
  assign pin_active = !pins_s[SPL_IX_RSTN] || pins_s[SPL_IX_HV];
  assign rise       = clk_s && !s_q.clk_prev;
  assign fall       = !clk_s && s_q.clk_prev;

  always_comb begin
    s_d          = s_q;
    s_d.clk_prev = clk_s;
    s_d.rx_valid = 1'b0;
    s_d.coll     = 1'b0;
    nsh          = {dat_s, s_q.sh[11:1]};
    tx_bit       = s_q.sh[0];
    // Link enable follows the pin; once programming is enabled only a
    // power-down reset can close the session
    if (!s_q.en && pin_active) begin
      s_d.en = 1'b1;
      s_d.st = SPL_RX_IDLE;
    end else if (s_q.en && !pin_active && !programming_enable_bit_i) begin
      s_d.en  = 1'b0;
      s_d.st  = SPL_OFF;
      s_d.oe  = 1'b0;
    end else begin
      case (s_q.st)
        SPL_OFF: begin
          s_d.oe = 1'b0;
        end
        SPL_RX_IDLE: begin
          if (tx_start_i) begin
            // Parity rides along with the data so the frame is self-contained
            s_d.sh        = {2'b11, ^tx_data_i, tx_data_i, 1'b0};
            s_d.guard     = 8'h00;
            s_d.bitc      = 4'h0;
            s_d.prev_zero = 1'b0;
            s_d.st        = SPL_TX_GUARD;
          end else if (rise && !dat_s) begin
            s_d.bitc = 4'h0;
            s_d.sh   = 12'h000;
            s_d.st   = SPL_RX_BITS;
          end
        end
        SPL_RX_BITS: begin
          if (rise) begin
            s_d.sh   = nsh;
            s_d.bitc = s_q.bitc + 4'h1;
            if (s_q.bitc == SPL_RX_LAST) begin
              s_d.rx_data  = nsh[8:1];
              s_d.rx_par   = nsh[9];
              s_d.rx_valid = 1'b1;
              s_d.perr     = ^nsh[9:1];
              s_d.ferr     = !nsh[10] || !nsh[11];
              s_d.brk      = (nsh[11:1] == 11'h000);
              // A break may last beyond the frame; wait for the line to rise
              s_d.st       = (!nsh[10] || !nsh[11]) ? SPL_RX_WAITH : SPL_RX_IDLE;
            end
          end
        end
        SPL_RX_WAITH: begin
          if (rise && dat_s) begin
            s_d.st = SPL_RX_IDLE;
          end
        end
        SPL_TX_GUARD: begin
          // Line is left to the pull-up while the guard bits run
          if (fall) begin
            s_d.guard = s_q.guard + 8'h01;
            if (s_q.guard == SPL_GUARD_TOTAL - 8'h01) begin
              s_d.oe        = 1'b1;
              s_d.dout      = tx_bit;
              s_d.prev_zero = !tx_bit;
              s_d.sh        = {1'b1, s_q.sh[11:1]};
              s_d.bitc      = 4'h1;
              s_d.st        = SPL_TX_BITS;
            end
          end
        end
        SPL_TX_BITS: begin
          if (rise && !s_q.oe && !dat_s) begin
            // Programmer pulled the released line low: stop at once
            s_d.coll = 1'b1;
            s_d.oe   = 1'b0;
            s_d.st   = SPL_RX_IDLE;
          end else if (fall) begin
            if (s_q.bitc == SPL_FRAME_BITS) begin
              s_d.oe = 1'b0;
              s_d.st = SPL_RX_IDLE;
            end else begin
              // Zeros always driven; a one only right after a zero, which
              // leaves gaps in which collisions can be seen
              s_d.oe        = !tx_bit || s_q.prev_zero;
              s_d.dout      = tx_bit;
              s_d.prev_zero = !tx_bit;
              s_d.sh        = {1'b1, s_q.sh[11:1]};
              s_d.bitc      = s_q.bitc + 4'h1;
            end
          end
        end
        default: begin
          s_d.st = SPL_OFF;
          s_d.oe = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (rst_i) begin
      s_q <= '{st: SPL_OFF, clk_prev: 1'b0, dout: 1'b1, default: '0};
    end else if (ce_i) begin
      s_q <= s_d;
    end
  end

  assign link_data_pin_o    = s_q.dout;
  assign link_data_pin_oe_o = s_q.oe;
  assign link_enabled_o     = s_q.en;
  assign rx_data_o          = s_q.rx_data;
  assign rx_valid_o         = s_q.rx_valid;
  assign rx_parity_err_o    = s_q.perr;
  assign rx_frame_err_o     = s_q.ferr;
  assign rx_break_o         = s_q.brk;
  assign tx_ready_o         = s_q.en && (s_q.st == SPL_RX_IDLE);
  assign tx_busy_o          = (s_q.st == SPL_TX_GUARD) || (s_q.st == SPL_TX_BITS);
  assign tx_collision_o     = s_q.coll;

  a_link_drops: assert property (@(posedge mclk_i) disable iff (rst_i)
    (ce_i && s_q.en && !pin_active && !programming_enable_bit_i) |=> !s_q.en)
    else $error("link stayed enabled after release with enable bit clear");
  a_session_kept: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.en && programming_enable_bit_i) |=> s_q.en)
    else $error("link closed while programming enable was set");
  a_parity_check: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_q.rx_valid |-> (s_q.perr == (^s_q.rx_data ^ s_q.rx_par)))
    else $error("parity error flag disagrees with received bits");
  a_break_frame: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.rx_valid && s_q.brk) |-> (s_q.ferr && s_q.rx_data == 8'h00 && s_q.st == SPL_RX_WAITH))
    else $error("break frame not flagged as frame error");
  a_zero_driven: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.st == SPL_TX_BITS && s_q.prev_zero) |-> (s_q.oe && !s_q.dout))
    else $error("zero bit not actively driven");
  a_collision_stop: assert property (@(posedge mclk_i) disable iff (rst_i)
    s_q.coll |-> (!s_q.oe && s_q.st == SPL_RX_IDLE))
    else $error("transmitter kept driving after collision");
  a_guard_quiet: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.st == SPL_TX_GUARD) |-> !s_q.oe)
    else $error("data line driven during guard time");
  a_guard_total: assert property (@(posedge mclk_i) disable iff (rst_i)
    (s_q.st == SPL_TX_BITS && $past(s_q.st) == SPL_TX_GUARD)
      |-> ($past(s_q.guard) == SPL_GUARD_TOTAL - 8'h01 && !s_q.dout))
    else $error("transmit began before guard bits elapsed");
  a_frame_length: assert property (@(posedge mclk_i) disable iff (rst_i)
    ($past(s_q.st) == SPL_TX_BITS && s_q.st == SPL_RX_IDLE && !s_q.coll)
      |-> ($past(s_q.bitc) == SPL_FRAME_BITS))
    else $error("transmitted frame length wrong");
endmodule
`default_nettype wire

// ### verification/spl_prog_model.sv
// Purpose: Programmer model at the far end of the serial programming link
// Assumes: The bench pulls the released data line high
// Notes:   Link clock stands still between frames, one bit per 125 ns
`timescale 1ns/1ns
`default_nettype none
module spl_prog_model (
  input  wire logic wire_i,
  output logic      clk_o,
  output logic      dat_o,
  output logic      oe_o
);
  initial begin
    clk_o = 1'b0;
    dat_o = 1'b1;
    oe_o  = 1'b0;
  end
  task automatic bit_out(input logic drv, input logic v, output logic seen);
    clk_o = 1'b0;
    oe_o  = drv;
    dat_o = v;
    #62;
    seen  = wire_i;
    clk_o = 1'b1;
    #63;
  endtask
  task automatic idle_bits(input int n);
    logic s;
    for (int i = 0; i < n; i++) bit_out(1'b1, 1'b1, s);
  endtask
  task automatic send_frame(input logic [7:0] b, input logic bad_par, input logic bad_stop);
    logic [11:0] f;
    logic        s;
    f = {1'b1, ~bad_stop, (^b) ^ bad_par, b, 1'b0};
    for (int i = 0; i < 12; i++) bit_out(1'b1, f[i], s);
  endtask
  task automatic send_break();
    logic s;
    for (int i = 0; i < 12; i++) bit_out(1'b1, 1'b0, s);
  endtask
  // Listens with the line released; jam pulls it low from the third data bit on
  task automatic get_frame(input logic jam, output int ones, output logic [10:0] bits);
    logic s;
    logic st;
    int   k;
    ones = 0;
    st   = 1'b0;
    k    = 0;
    bits = '0;
    for (int i = 0; i < 200 && k < 11; i++) begin
      bit_out(jam && k > 1, 1'b0, s);
      if (!st && s) ones++;
      else if (!st) st = 1'b1;
      else begin
        bits[k] = s;
        k++;
      end
    end
    oe_o = 1'b0;
  endtask
endmodule
`default_nettype wire

// ### verification/tb.sv
// Purpose: Self-checking bench for the serial programming link block
// Assumes: Clock enable stays high except for one command write made with it low
// Notes:   Random bytes come from a fixed seed so runs repeat
`timescale 1ns/1ns
`default_nettype none
module tb
  import spl_pkg::*;
;
  logic        mclk, rst, rstn, hv, lclk, wire_l, pin_o, pin_oe, p_d, p_oe, pen, en;
  logic        rxv, pe, fe, brk, txs, txr, txb, coll, wr, selfp, memwr, memhi, done;
  logic        busy, go, ec, el, wc, ce;
  logic [7:0]  rxd, txd, wdata, rdata, d, b;
  logic [5:0]  addr, cmd, ex;
  logic [10:0] bits;
  int          err_total, comparisons, rx_cnt, rx_seen, go_cnt, coll_cnt, g, ones;
  logic [5:0]  cmds [6] = '{SPL_CMD_NOP, SPL_CMD_CHIP_ER, SPL_CMD_CHIP_WR,
                            SPL_CMD_SECT_ER, SPL_CMD_WORD_WR, SPL_CMD_PAGE_ER};
  // Pull-up wins whenever nobody drives the data line
  assign wire_l = (pin_oe === 1'b1) ? pin_o : ((p_oe === 1'b1) ? p_d : 1'b1);
  spl_link dut (.mclk_i(mclk), .rst_i(rst), .ce_i(ce), .link_reset_n_i(rstn),
    .link_hv_i(hv), .link_clock_pin_i(lclk), .link_data_pin_i(wire_l),
    .link_data_pin_o(pin_o), .link_data_pin_oe_o(pin_oe), .programming_enable_bit_i(pen),
    .link_enabled_o(en), .rx_data_o(rxd), .rx_valid_o(rxv), .rx_parity_err_o(pe),
    .rx_frame_err_o(fe), .rx_break_o(brk), .tx_start_i(txs), .tx_data_i(txd),
    .tx_ready_o(txr), .tx_busy_o(txb), .tx_collision_o(coll), .io_addr_i(addr),
    .io_wr_i(wr), .io_wdata_i(wdata), .io_rdata_o(rdata), .self_prog_i(selfp),
    .mem_wr_i(memwr), .mem_hi_byte_i(memhi), .nvm_done_i(done),
    .memory_busy_flag_o(busy), .nvm_go_o(go), .nvm_cmd_o(cmd), .erase_code_o(ec),
    .erase_lock_o(el), .write_code_o(wc));
  spl_prog_model prog (.wire_i(wire_l), .clk_o(lclk), .dat_o(p_d), .oe_o(p_oe));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  always @(posedge mclk) begin
    if (rxv === 1'b1) rx_cnt++;
    if (go === 1'b1) go_cnt++;
    if (coll === 1'b1) coll_cnt++;
  end
  task automatic tick();
    @(posedge mclk);
    #1;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [5:0] a, input logic [7:0] v);
    addr  = a;
    wdata = v;
    wr    = 1'b1;
    tick();
    wr    = 1'b0;
  endtask
  task automatic rd_reg(input logic [5:0] a, input logic [7:0] exp, input string what);
    addr = a;
    tick();
    chk(rdata, exp, what);
  endtask
  task automatic rx_check(input logic [7:0] v, input logic p, input logic f, input logic k);
    repeat (6) tick();
    chk(8'(rx_cnt - rx_seen), 8'h01, "frame count");
    rx_seen = rx_cnt;
    chk(rxd, v, "rx data");
    chk({5'h00, pe, fe, brk}, {5'h00, p, f, k}, "rx flags");
  endtask
  task automatic send_tx(input logic [7:0] v);
    for (int i = 0; i < 50 && txr !== 1'b1; i++) tick();
    chk({7'h00, txr}, 8'h01, "tx ready");
    txd = v;
    txs = 1'b1;
    tick();
    txs = 1'b0;
  endtask
  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    #400_000;
    err_total++;
    wrap_up();
  end
  initial begin
    {rst, hv, pen, txs, txd, wr, wdata, addr, selfp, memwr, memhi, done} = '0;
    rst = 1'b1;
    rstn = 1'b1;
    ce = 1'b1;
    {err_total, comparisons, rx_cnt, rx_seen, go_cnt, coll_cnt} = '0;
    void'($urandom(62224));
    repeat (8) @(posedge mclk);
    #1;
    rst = 1'b0;
    rd_reg(SPL_CSR_ADDR, 8'h00, "status reset");
    rd_reg(SPL_CMD_ADDR, 8'h00, "command reset");
    wr_reg(SPL_CSR_ADDR, 8'hFF);
    rd_reg(SPL_CSR_ADDR, 8'h00, "status write");
    rd_reg(6'h05, 8'h00, "unmapped");
    // A write while the clock enable is low must leave the command untouched
    ce = 1'b0;
    wr_reg(SPL_CMD_ADDR, {2'b00, SPL_CMD_CHIP_ER});
    ce = 1'b1;
    rd_reg(SPL_CMD_ADDR, 8'h00, "frozen");
    for (int i = 0; i < 6; i++) begin
      wr_reg(SPL_CMD_ADDR, {2'b11, cmds[i]});
      rd_reg(SPL_CMD_ADDR, {2'b00, cmds[i]}, "command");
      g = go_cnt;
      memwr = 1'b1;
      memhi = 1'b1;
      tick();
      {memwr, memhi} = '0;
      repeat (20) tick();
      chk(8'(go_cnt - g), {7'h00, cmds[i] != 6'h00}, "start");
      chk({2'b00, cmd}, {2'b00, cmds[i]}, "command out");
      rd_reg(SPL_CSR_ADDR, {cmds[i] != 6'h00, 7'h00}, "busy");
      if (cmds[i] inside {SPL_CMD_CHIP_ER, SPL_CMD_CHIP_WR, SPL_CMD_SECT_ER})
        chk({5'h00, ec, el, wc}, {5'h00, cmds[i] != SPL_CMD_CHIP_WR,
            cmds[i] == SPL_CMD_CHIP_ER, cmds[i] == SPL_CMD_CHIP_WR}, "decode");
      wr_reg(SPL_CMD_ADDR, 8'h3F);
      rd_reg(SPL_CMD_ADDR, {2'b00, (cmds[i] != 6'h00) ? cmds[i] : 6'h3F}, "blocked");
      done = 1'b1;
      tick();
      done = 1'b0;
      tick();
      rd_reg(SPL_CSR_ADDR, 8'h00, "busy end");
    end
    $display("test registers done");
    selfp = 1'b1;
    ex = 6'h3F;
    for (int i = 0; i < 6; i++) begin
      wr_reg(SPL_CMD_ADDR, {2'b00, cmds[i]});
      if (cmds[i] inside {SPL_CMD_NOP, SPL_CMD_WORD_WR, SPL_CMD_PAGE_ER}) ex = cmds[i];
      rd_reg(SPL_CMD_ADDR, {2'b00, ex}, "self command");
    end
    selfp = 1'b0;
    $display("test self programming done");
    rstn = 1'b0;
    repeat (6) tick();
    chk({7'h00, en}, 8'h01, "enable");
    prog.idle_bits(16);
    rx_seen = rx_cnt;
    for (int i = 0; i < 6; i++) begin
      b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
      prog.send_frame(b, 1'b0, 1'b0);
      rx_check(b, 1'b0, 1'b0, 1'b0);
    end
    b = 8'($urandom);
    prog.send_frame(b, 1'b1, 1'b0);
    rx_check(b, 1'b1, 1'b0, 1'b0);
    prog.send_frame(b, 1'b0, 1'b1);
    rx_check(b, 1'b0, 1'b1, 1'b0);
    prog.idle_bits(2);
    prog.send_break();
    rx_check(8'h00, 1'b0, 1'b1, 1'b1);
    prog.idle_bits(2);
    $display("test receive done");
    send_tx(8'($urandom));
    prog.get_frame(1'b0, ones, bits);
    chk({7'h00, ones >= 129 && ones <= 130}, 8'h01, "guard bits");
    chk(bits[7:0], txd, "tx data");
    chk({6'h00, bits[10:9]}, {7'h00, ^txd} * 8'h00 + 8'h03, "tx stops");
    chk({7'h00, bits[8]}, {7'h00, ^txd}, "tx parity");
    prog.idle_bits(2);
    g = coll_cnt;
    send_tx(8'hFF);
    prog.get_frame(1'b1, ones, bits);
    chk(8'(coll_cnt - g), 8'h01, "collision");
    chk({7'h00, pin_oe}, 8'h00, "released");
    prog.send_break();
    prog.idle_bits(14);
    $display("test transmit done");
    pen = 1'b1;
    rstn = 1'b1;
    repeat (8) tick();
    chk({7'h00, en}, 8'h01, "kept");
    pen = 1'b0;
    repeat (8) tick();
    chk({7'h00, en}, 8'h00, "left");
    hv = 1'b1;
    repeat (8) tick();
    chk({7'h00, en}, 8'h01, "hv enable");
    hv = 1'b0;
    repeat (8) tick();
    chk({7'h00, en}, 8'h00, "hv left");
    $display("test enable done");
    wrap_up();
  end
endmodule
`default_nettype wire
